/* File: page_translate.v */
// data space page translation: maps effective addresses onto paged windows
// assumes cpu address logic on clk_in presents one access per request pulse
// Function
// RULE1 - separate read and write page selectors
// RULE2 - one request moves word read page to write page; code takes a read request then a write request
// RULE3 - page crossing clears address bit fifteen first
// RULE4 - crossing detection only for pre/post modified indirect
// RULE5 - overflow increments page and sets top bit
// RULE6 - underflow decrements page and sets top bit
// RULE7 - offset, modulo, bit-reverse wrap within current page
// RULE8 - boundary pages stay, clear top bit, base space
// RULE9 - page 0x2FF and 0x300 cross with top bit
// RULE10 - paged access with page zero traps; code exempts direct mode
// RULE11 - program space writes through write page trap
// RULE12 - caller avoids large offsets when crossing pages
// RULE13 - ten bit pages decode eds, low, upper
`include "page_translate_regs.vh"
module page_translate (
    input wire clk_in,
    input wire rst_n_in,
    input wire page_load_in,
    input wire [`PAGE_W-1:0] read_page_in,
    input wire [`PAGE_W-1:0] write_page_in,
    input wire req_in,
    input wire is_write_in,
    input wire move_in,
    input wire [`MODE_W-1:0] mode_in,
    input wire [15:0] base_addr_in,
    input wire [15:0] mod_addr_in,
    input wire carry_in,
    input wire borrow_in,
    output reg valid_out,
    output reg [15:0] effective_addr_out,
    output reg [`PAGE_W-1:0] page_out,
    output reg [1:0] space_kind_out,
    output reg write_out,
    output reg move_out,
    output reg [`PAGE_W-1:0] read_page_select_out,
    output reg [`PAGE_W-1:0] write_page_select_out,
    output reg addr_error_out
);

////////////////////////////////////////////////////////////////////////////////
// page decoding used for both selectors
function [1:0] page_kind;
    input [`PAGE_W-1:0] p;
    begin
        if (p == `PAGE_ZERO) begin
            page_kind = `KIND_BASE;
        end else if (p <= `PAGE_EDS_LAST) begin
            page_kind = `KIND_EDS; // RULE13
        end else begin
            page_kind = `KIND_PSV; // RULE13
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// selector state
reg [`PAGE_W-1:0] read_page_select_r;
reg [`PAGE_W-1:0] write_page_select_r;
reg [`PAGE_W-1:0] rd_nxt;
reg [`PAGE_W-1:0] wr_nxt;

// combinational translation
reg [`PAGE_W-1:0] active_page_select;
reg [`PAGE_W-1:0] page_nxt;
reg [15:0] effective_addr;
reg paged;
reg modified;
reg wrap_mode;
reg crossing;
reg trap;
reg trap_page_zero;
reg trap_prog_write;
reg [1:0] kind_nxt;

// boundary decode of the active page
reg ovf_stay;
reg unf_stay;
reg ovf_to_upper;
reg unf_to_lower;

////////////////////////////////////////////////////////////////////////////////
// which selector serves this access and whether it crosses a page edge
always @* begin
    // write page for writes, read page for reads
    active_page_select = is_write_in ? write_page_select_r : read_page_select_r; // RULE1
    // top bit of the unmodified address marks the paged window
    paged = base_addr_in[`EA_MSB] && (active_page_select != `PAGE_ZERO);
    modified = (mode_in == `MODE_PRE_MOD) || (mode_in == `MODE_POST_MOD); // RULE4
    wrap_mode = (mode_in == `MODE_REG_OFFSET) || (mode_in == `MODE_MODULO) || (mode_in == `MODE_BIT_REV);
    crossing = paged && (carry_in || borrow_in);
end

////////////////////////////////////////////////////////////////////////////////
// pages whose crossing does not simply step the selector
always @* begin
    // last data page and last upper page fall back to base space
    ovf_stay = (active_page_select == `PAGE_EDS_LAST) || (active_page_select == `PAGE_MSB_LAST); // RULE8
    // first data page and first low word page fall back to base space
    unf_stay = (active_page_select == `PAGE_EDS_FIRST) || (active_page_select == `PAGE_LSW_FIRST); // RULE8
    // reads walk from the low word pages into the upper pages and back
    ovf_to_upper = !is_write_in && (active_page_select == `PAGE_LSW_LAST); // RULE9
    unf_to_lower = !is_write_in && (active_page_select == `PAGE_MSB_FIRST); // RULE9
end

////////////////////////////////////////////////////////////////////////////////
// effective address and next page for the access
always @* begin
    effective_addr = mod_addr_in;
    page_nxt = active_page_select;
    if (crossing) begin
        // crossing clears the top bit before any correction
        effective_addr[`EA_MSB] = 1'b0; // RULE3
        if (wrap_mode) begin
            // page kept, top bit set so the address wraps within this page
            effective_addr[`EA_MSB] = 1'b1; // RULE7
        end else if (modified && carry_in) begin
            // overflow side: cross upward, fall back, or step
            if (ovf_to_upper) begin
                page_nxt = `PAGE_MSB_FIRST; // RULE9
                effective_addr[`EA_MSB] = 1'b1;
            end else if (ovf_stay) begin
                effective_addr[`EA_MSB] = 1'b0; // RULE8
            end else begin
                page_nxt = active_page_select + 10'h001; // RULE5
                effective_addr[`EA_MSB] = 1'b1;
            end
        end else if (modified && borrow_in) begin
            // underflow side: cross downward, fall back, or step
            if (unf_to_lower) begin
                page_nxt = `PAGE_LSW_LAST; // RULE9
                effective_addr[`EA_MSB] = 1'b1;
            end else if (unf_stay) begin
                effective_addr[`EA_MSB] = 1'b0; // RULE8
            end else begin
                page_nxt = active_page_select - 10'h001; // RULE6
                effective_addr[`EA_MSB] = 1'b1;
            end
        end
    end
    // a cleared top bit lands in the base data space
    kind_nxt = effective_addr[`EA_MSB] ? page_kind(page_nxt) : `KIND_BASE;
end

////////////////////////////////////////////////////////////////////////////////
// address error conditions
always @* begin
    // paged access through page zero has no window behind it
    trap_page_zero = base_addr_in[`EA_MSB] && (active_page_select == `PAGE_ZERO)
        && (mode_in != `MODE_DIRECT); // RULE10
    // program space is reachable for reads only
    trap_prog_write = is_write_in && base_addr_in[`EA_MSB]
        && (page_kind(write_page_select_r) == `KIND_PSV); // RULE11
    trap = trap_page_zero || trap_prog_write;
end

////////////////////////////////////////////////////////////////////////////////
// next selector values
always @* begin
    rd_nxt = read_page_select_r;
    wr_nxt = write_page_select_r;
    // a load wins over a request in the same cycle
    if (page_load_in) begin
        rd_nxt = read_page_in;
        wr_nxt = write_page_in;
    end else if (req_in && !trap) begin
        // a trapped access leaves both selectors alone
        if (is_write_in) begin
            wr_nxt = page_nxt;
        end else begin
            rd_nxt = page_nxt;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// selector state and its copies on the ports
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        read_page_select_r <= `PAGE_RESET;
        write_page_select_r <= `PAGE_RESET;
        read_page_select_out <= `PAGE_RESET;
        write_page_select_out <= `PAGE_RESET;
    end else begin
        read_page_select_r <= rd_nxt; // RULE1
        write_page_select_r <= wr_nxt; // RULE1
        // ports copy the next value so they stay flop driven
        read_page_select_out <= rd_nxt;
        write_page_select_out <= wr_nxt;
    end
end

////////////////////////////////////////////////////////////////////////////////
// one answer pulse per request, one cycle later
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        valid_out <= 1'b0;
        addr_error_out <= 1'b0;
        write_out <= 1'b0;
        move_out <= 1'b0;
    end else begin
        // exactly one of valid and error follows a request
        valid_out <= req_in && !trap;
        addr_error_out <= req_in && trap; // RULE10
        write_out <= is_write_in;
        // a move is a read request then a write request
        move_out <= req_in && move_in; // RULE2
    end
end

////////////////////////////////////////////////////////////////////////////////
// translated address, page and space of the access
always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
        effective_addr_out <= `EA_RESET;
        page_out <= `PAGE_ZERO;
        space_kind_out <= `KIND_BASE;
    end else begin
        effective_addr_out <= effective_addr; // RULE3
        page_out <= page_nxt;
        space_kind_out <= kind_nxt; // RULE13
    end
end

endmodule

/* File: page_translate_regs.vh */
// constants for the data space page translation block
// assumes inclusion by the design file and the assertion file
`ifndef PAGE_TRANSLATE_REGS_VH
`define PAGE_TRANSLATE_REGS_VH
`define PAGE_W 10
`define PAGE_RESET 10'h001
`define PAGE_ZERO 10'h000
`define PAGE_EDS_FIRST 10'h001
`define PAGE_EDS_LAST 10'h1FF
`define PAGE_LSW_FIRST 10'h200
`define PAGE_LSW_LAST 10'h2FF
`define PAGE_MSB_FIRST 10'h300
`define PAGE_MSB_LAST 10'h3FF
`define EA_MSB 15
`define EA_RESET 16'h0000
`define MODE_W 3
`define MODE_DIRECT 3'h0
`define MODE_PRE_MOD 3'h1
`define MODE_POST_MOD 3'h2
`define MODE_REG_OFFSET 3'h3
`define MODE_MODULO 3'h4
`define MODE_BIT_REV 3'h5
`define KIND_BASE 2'h0
`define KIND_EDS 2'h1
`define KIND_PSV 2'h2
`endif

/* File: page_translate_props.sv */
// port assertions for page_translate
// bound to every instance; one clock, async low reset
`include "page_translate_regs.vh"
module page_translate_props (
    input wire clk_in, rst_n_in, page_load_in, req_in, is_write_in, carry_in, borrow_in, valid_out, addr_error_out,
    input wire [2:0] mode_in,
    input wire [15:0] base_addr_in, effective_addr_out,
    input wire [9:0] read_page_select_out, write_page_select_out,
    input wire [1:0] space_kind_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // paged request qualifiers
    wire go = req_in & ~page_load_in & base_addr_in[15];
    wire rd = go & ~is_write_in;
    wire [9:0] rp = read_page_select_out;
    sequence rd_ovf;
        rd && mode_in == 3'h2 && carry_in && !borrow_in;
    endsequence
    ans_one_a:
    assert property (req_in && !page_load_in |=> valid_out != addr_error_out) else $error("no single answer");
    zero_trap_a:
    assert property (rd && mode_in != 3'h0 && rp == 10'h0 |=> addr_error_out) else $error("page zero passed");
    psv_write_a:
    assert property (go && is_write_in && mode_in != 3'h0 && write_page_select_out >= 10'h200
        |=> addr_error_out && !valid_out) else $error("program write passed");
    ovf_inc_a:
    assert property (rd_ovf ##0 rp >= 10'h1 && rp < 10'h1FF |=> rp == $past(rp) + 10'h1 && effective_addr_out[15])
        else $error("overflow step wrong");
    unf_dec_a:
    assert property (rd && mode_in == 3'h1 && borrow_in && !carry_in && rp > 10'h1 && rp < 10'h200
        |=> rp == $past(rp) - 10'h1 && effective_addr_out[15]) else $error("underflow step wrong");
    wrap_keep_a:
    assert property (rd && mode_in >= 3'h3 && mode_in <= 3'h5 && (carry_in || borrow_in) && rp != 10'h0 && rp < 10'h200
        |=> $stable(rp) && effective_addr_out[15]) else $error("wrap moved page");
    edge_base_a:
    assert property (rd_ovf ##0 rp == 10'h1FF |=> rp == 10'h1FF && !effective_addr_out[15] && space_kind_out == 2'h0)
        else $error("last page not to base");
    psv_cross_a:
    assert property (rd_ovf ##0 rp == 10'h2FF |=> rp == 10'h300 && effective_addr_out[15]) else $error("psv cross wrong");
    read_hold_a:
    assert property (req_in && is_write_in && !page_load_in |=> $stable(rp)) else $error("write moved read page");
endmodule
bind page_translate page_translate_props u_props (.*);

/* File: page_addr_gen.sv */
// partner: cpu address step of two with page carry and borrow
// assumes the block samples these at its request edge
module page_addr_gen (
    input wire [15:0] base_in,
    input wire dec_in,
    output wire [15:0] mod_out,
    output wire carry_out,
    output wire borrow_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // small steps only, never a large offset
    wire [16:0] sum = dec_in ? {1'b0, base_in} - 17'h00002 : {1'b0, base_in} + 17'h00002;
    assign mod_out = sum[15:0];
    assign carry_out = ~dec_in & sum[16];
    assign borrow_out = dec_in & base_in[15] & ~sum[15];
endmodule

/* File: test_page_translate.sv */
// self-checking bench for page_translate
// drives at the rising edge; partner forms carries
module test_page_translate;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk_in = 0, rst_n_in = 0, page_load_in = 0, req_in = 0, is_write_in = 0, move_in = 0, dec = 0;
    reg [9:0] rp = 0, wp = 0;
    reg [2:0] mode_in = 0;
    reg [15:0] base = 0;
    wire [15:0] mod, ea;
    wire [9:0] pg, rps, wps;
    wire [1:0] sk;
    wire cy, bw, vld, wo, mo, err;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    page_addr_gen u_gen (.base_in(base), .dec_in(dec), .mod_out(mod), .carry_out(cy), .borrow_out(bw));
    page_translate u_dut (.clk_in, .rst_n_in, .page_load_in, .read_page_in(rp), .write_page_in(wp), .req_in,
        .is_write_in, .move_in, .mode_in, .base_addr_in(base), .mod_addr_in(mod), .carry_in(cy), .borrow_in(bw),
        .valid_out(vld), .effective_addr_out(ea), .page_out(pg), .space_kind_out(sk), .write_out(wo), .move_out(mo),
        .read_page_select_out(rps), .write_page_select_out(wps), .addr_error_out(err));
    ////////////////////////////////////////
    // clock and hang ceiling
    initial forever #4 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            error_cnt++;
            test_done;
        end
    end
    task test_done;
        if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task cmp(input [35:0] g, e);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %0t got %h want %h", $time, g, e);
        end
    endtask
    task load(input [9:0] r, w);
        @(posedge clk_in);
        {page_load_in, rp, wp} <= {1'b1, r, w};
        @(posedge clk_in);
        page_load_in <= 0;
    endtask
    // one request, answer looked at one cycle later
    task acc(input w, input [2:0] m, input [15:0] b, input d, mv);
        @(posedge clk_in);
        {req_in, is_write_in, mode_in, base, dec, move_in} <= {1'b1, w, m, b, d, mv};
        @(posedge clk_in);
        req_in <= 0;
        #1;
    endtask
    ////////////////////////////////////////
    task t_cross;
        load(10'h005, 10'h005);
        acc(0, 2, 16'hFFFE, 0, 0);
        cmp({rps, ea[15]}, {10'h006, 1'b1});
        cmp(sk, 2'h1);
        acc(0, 1, 16'h8000, 1, 0);
        cmp(ea, 16'hFFFE);
        cmp({rps, wps}, {10'h005, 10'h005});
    endtask
    task t_wrap;
        load(10'h005, 10'h005);
        for (int m = 3; m < 6; m++) begin
            acc(0, m[2:0], 16'hFFFE, 0, 0);
            cmp({rps, ea}, {10'h005, 16'h8000});
        end
    endtask
    task t_edge;
        acc(0, 1, 16'h8000, 1, 0);
        cmp({rps, ea}, {10'h001, 16'h7FFE});
        load(10'h1FF, 10'h1FF);
        acc(0, 2, 16'hFFFE, 0, 0);
        cmp({sk, ea}, 0);
        acc(1, 2, 16'hFFFE, 0, 0);
        cmp({rps, wps, ea}, {10'h1FF, 10'h1FF, 16'h0});
        load(10'h2FF, 10'h001);
        acc(0, 2, 16'hFFFE, 0, 0);
        cmp({rps, ea[15]}, {10'h300, 1'b1});
        cmp(sk, 2'h2);
        acc(0, 1, 16'h8000, 1, 0);
        cmp({rps, ea[15]}, {10'h2FF, 1'b1});
    endtask
    task t_trap;
        load(10'h000, 10'h200);
        acc(0, 2, 16'h8000, 0, 0);
        cmp({err, vld}, 2'b10);
        acc(1, 2, 16'h8000, 0, 0);
        cmp({err, vld}, 2'b10);
    endtask
    task t_move;
        load(10'h205, 10'h007);
        acc(0, 2, 16'h8000, 0, 1);
        cmp({mo, wo, pg}, {2'b10, 10'h205});
        cmp({err, vld}, 2'b01);
        acc(1, 2, 16'h8000, 0, 1);
        cmp({mo, wo, pg}, {2'b11, 10'h007});
    endtask
    initial begin
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1;
        #1;
        cmp({rps, wps}, {10'h001, 10'h001});
        t_edge;
        t_cross;
        t_wrap;
        t_trap;
        t_move;
        test_done;
    end
endmodule
